// File: verilog/bbn_pkg.sv
// Package of offsets, reset values, field positions and carriers for the bus-number bank
package bbn_pkg;

    // ********************************************
    // Register byte offsets in configuration space
    // ********************************************
    localparam logic [7:0] UPSTREAM_BUS_OFS = 8'h18;
    localparam logic [7:0] DOWNSTREAM_BUS_OFS = 8'h19;
    localparam logic [7:0] HIGHEST_BELOW_OFS = 8'h1A;
    localparam logic [7:0] LATENCY_TIMER_OFS = 8'h1B;
    localparam logic [7:0] IO_BOTTOM_OFS = 8'h1C;
    localparam logic [7:0] IO_TOP_OFS = 8'h1D;
    // Dword indices of the two words that this bank answers
    localparam logic [5:0] BUS_WORD_IDX = 6'h06;
    localparam logic [5:0] IO_WORD_IDX = 6'h07;

    // ********************************************
    // Reset values and field layout
    // ********************************************
    localparam logic [7:0] BUS_NUM_RST = 8'h00;
    localparam logic [7:0] LAT_TIMER_RST = 8'h00;
    localparam logic [3:0] IO_NIBBLE_RST = 4'h0;
    localparam logic [3:0] IO_ADDRESSING_CAPABILITY = 4'h1; // 32-bit I/O decode
    localparam int IO_NIBBLE_LSB = 4;
    localparam logic [11:0] IO_BOTTOM_LOW = 12'h000;
    localparam logic [11:0] IO_TOP_LOW = 12'hFFF;

    // ********************************************
    // Carriers
    // ********************************************
    // One configuration access on the upstream link, dword addressed with byte enables
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] dw_idx;
        logic [3:0] be;
        logic [31:0] wdata;
    } bbn_cfg_req_type;

    // Read completion
    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
    } bbn_cfg_rsp_type;

    // Verdict on a type-1 configuration request
    typedef struct packed {
        logic valid;
        logic to_type0;
        logic pass_type1;
        logic unclaimed;
    } bbn_cfg1_rsp_type;

    // Verdict on an I/O transaction
    typedef struct packed {
        logic valid;
        logic forward;
    } bbn_io_rsp_type;

endpackage

// File: verilog/bbn_regs.sv
// Bus number, latency timer and I/O window register bank with its decoders
`timescale 1ns/1ps
// Summary of operation
// - Upstream bus number: 8-bit read/write, resets to zero.
// - Downstream bus number: 8-bit read/write, reset zero, steers type-1 answers.
// - Highest-below bus number: 8-bit read/write, reset zero, used in type-1 decode.
// - Downstream latency timer: 8-bit read/write, reset zero, in downstream clocks.
// - Forward I/O only when address lies within bottom and top, inclusive.
// - Bottom nibble gives address bits 15:12; bits 11:0 of bottom are zero.
// - Top nibble gives address bits 15:12; bits 11:0 of top are ones.
// - Bottom address bits 31:16 come from the base-extension register.
// - Top address bits 31:16 come from the limit-extension register.
// - Low nibbles of both window bytes read-only one: 32-bit I/O capable.
module bbn_regs #(
    parameter int BUS_NUM_W = 8
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    // Configuration access from the upstream link
    input wire bbn_pkg::bbn_cfg_req_type CFG_REQ_I,
    output bbn_pkg::bbn_cfg_rsp_type CFG_RSP_O,
    // Upper 16 window bits held in the extension registers
    input wire logic [15:0] IO_BASE_UPPER_I,
    input wire logic [15:0] IO_LIMIT_UPPER_I,
    // Type-1 configuration request decode
    input wire logic CFG1_VALID_I,
    input wire logic [7:0] CFG1_BUS_I,
    output bbn_pkg::bbn_cfg1_rsp_type CFG1_RSP_O,
    // I/O forwarding decode
    input wire logic IO_VALID_I,
    input wire logic [31:0] IO_ADDR_I,
    output bbn_pkg::bbn_io_rsp_type IO_RSP_O,
    // Register values for the rest of the bridge
    output logic [7:0] UPSTREAM_BUS_O,
    output logic [7:0] LATENCY_TIMER_O
);

    // ********************************************
    // Elaboration check
    // ********************************************
    // Bus numbers are byte fields of the header; no other width can be served
    if (BUS_NUM_W != 8)
    begin : g_width_check
        $error("BUS_NUM_W must be 8");
    end

    // ********************************************
    // Register storage
    // ********************************************
    logic [7:0] upstream_bus_q, upstream_bus_d;
    logic [7:0] downstream_bus_q, downstream_bus_d;
    logic [7:0] highest_below_q, highest_below_d;
    logic [7:0] latency_timer_q, latency_timer_d;
    logic [3:0] io_window_bottom_nibble_q, io_window_bottom_nibble_d;
    logic [3:0] io_window_top_nibble_q, io_window_top_nibble_d;
    logic bus_word_hit;
    logic io_word_hit;

    assign bus_word_hit = CFG_REQ_I.dw_idx == bbn_pkg::BUS_WORD_IDX;
    assign io_word_hit = CFG_REQ_I.dw_idx == bbn_pkg::IO_WORD_IDX;

    // Byte-lane writes; the low nibble of each window byte has no storage at all
    always_comb
    begin
        upstream_bus_d = upstream_bus_q;
        downstream_bus_d = downstream_bus_q;
        highest_below_d = highest_below_q;
        latency_timer_d = latency_timer_q;
        io_window_bottom_nibble_d = io_window_bottom_nibble_q;
        io_window_top_nibble_d = io_window_top_nibble_q;
        if (CFG_REQ_I.wr && bus_word_hit)
        begin
            if (CFG_REQ_I.be[0])
                upstream_bus_d = CFG_REQ_I.wdata[7:0];
            if (CFG_REQ_I.be[1])
                downstream_bus_d = CFG_REQ_I.wdata[15:8];
            if (CFG_REQ_I.be[2])
                highest_below_d = CFG_REQ_I.wdata[23:16];
            if (CFG_REQ_I.be[3])
                latency_timer_d = CFG_REQ_I.wdata[31:24];
        end
        if (CFG_REQ_I.wr && io_word_hit)
        begin
            if (CFG_REQ_I.be[0])
                io_window_bottom_nibble_d = CFG_REQ_I.wdata[7:4];
            if (CFG_REQ_I.be[1])
                io_window_top_nibble_d = CFG_REQ_I.wdata[15:12];
        end
    end

    // Storage flops
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            upstream_bus_q <= bbn_pkg::BUS_NUM_RST;
            downstream_bus_q <= bbn_pkg::BUS_NUM_RST;
            highest_below_q <= bbn_pkg::BUS_NUM_RST;
            latency_timer_q <= bbn_pkg::LAT_TIMER_RST;
            io_window_bottom_nibble_q <= bbn_pkg::IO_NIBBLE_RST;
            io_window_top_nibble_q <= bbn_pkg::IO_NIBBLE_RST;
        end
        else
        begin
            upstream_bus_q <= upstream_bus_d;
            downstream_bus_q <= downstream_bus_d;
            highest_below_q <= highest_below_d;
            latency_timer_q <= latency_timer_d;
            io_window_bottom_nibble_q <= io_window_bottom_nibble_d;
            io_window_top_nibble_q <= io_window_top_nibble_d;
        end
    end

    // ********************************************
    // Read completions
    // ********************************************
    bbn_pkg::bbn_cfg_rsp_type cfg_rsp_q, cfg_rsp_d;
    logic [7:0] io_bottom_byte;
    logic [7:0] io_top_byte;

    // Low nibble is the fixed capability code on every read
    assign io_bottom_byte = {io_window_bottom_nibble_q, bbn_pkg::IO_ADDRESSING_CAPABILITY};
    assign io_top_byte = {io_window_top_nibble_q, bbn_pkg::IO_ADDRESSING_CAPABILITY};

    // Whole dword returned; unmapped words and the status half read as zero
    always_comb
    begin
        cfg_rsp_d.valid = CFG_REQ_I.rd;
        cfg_rsp_d.rdata = 32'h0000_0000;
        if (CFG_REQ_I.rd && bus_word_hit)
            cfg_rsp_d.rdata = {latency_timer_q, highest_below_q, downstream_bus_q, upstream_bus_q};
        else if (CFG_REQ_I.rd && io_word_hit)
            cfg_rsp_d.rdata = {16'h0000, io_top_byte, io_bottom_byte};
    end

    // Completion flops
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            cfg_rsp_q <= '0;
        else
            cfg_rsp_q <= cfg_rsp_d;
    end

    // ********************************************
    // Type-1 configuration decode
    // ********************************************
    bbn_pkg::bbn_cfg1_rsp_type cfg1_rsp_q, cfg1_rsp_d;

    // Exact match turns into a type-0 cycle, deeper buses travel on as type-1
    always_comb
    begin
        cfg1_rsp_d.valid = CFG1_VALID_I;
        cfg1_rsp_d.to_type0 = CFG1_VALID_I && (CFG1_BUS_I == downstream_bus_q);
        cfg1_rsp_d.pass_type1 = CFG1_VALID_I && (CFG1_BUS_I > downstream_bus_q)
            && (CFG1_BUS_I <= highest_below_q);
        cfg1_rsp_d.unclaimed = CFG1_VALID_I && !cfg1_rsp_d.to_type0 && !cfg1_rsp_d.pass_type1;
    end

    // Verdict flops
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            cfg1_rsp_q <= '0;
        else
            cfg1_rsp_q <= cfg1_rsp_d;
    end

    // ********************************************
    // I/O window decode
    // ********************************************
    bbn_pkg::bbn_io_rsp_type io_rsp_q, io_rsp_d;
    logic [31:0] io_bottom_addr;
    logic [31:0] io_top_addr;

    assign io_bottom_addr = {IO_BASE_UPPER_I, io_window_bottom_nibble_q,
        bbn_pkg::IO_BOTTOM_LOW};
    assign io_top_addr = {IO_LIMIT_UPPER_I, io_window_top_nibble_q,
        bbn_pkg::IO_TOP_LOW};

    // A top below the bottom gives an empty window, so nothing is forwarded
    always_comb
    begin
        io_rsp_d.valid = IO_VALID_I;
        io_rsp_d.forward = IO_VALID_I && (IO_ADDR_I >= io_bottom_addr)
            && (IO_ADDR_I <= io_top_addr);
    end

    // Verdict flops
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            io_rsp_q <= '0;
        else
            io_rsp_q <= io_rsp_d;
    end

    // ********************************************
    // Outputs
    // ********************************************
    assign CFG_RSP_O = cfg_rsp_q;
    assign CFG1_RSP_O = cfg1_rsp_q;
    assign IO_RSP_O = io_rsp_q;
    assign UPSTREAM_BUS_O = upstream_bus_q;
    assign LATENCY_TIMER_O = latency_timer_q;

    // ********************************************
    // Assertions
    // ********************************************
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence bus_word_write_s;
        CFG_REQ_I.wr && bus_word_hit && (CFG_REQ_I.be == 4'hF);
    endsequence

    sequence bus_word_read_s;
        CFG_REQ_I.rd && !CFG_REQ_I.wr && bus_word_hit;
    endsequence

    sequence io_word_write_s;
        CFG_REQ_I.wr && io_word_hit && (CFG_REQ_I.be[1:0] == 2'b11);
    endsequence

    sequence io_word_read_s;
        CFG_REQ_I.rd && !CFG_REQ_I.wr && io_word_hit;
    endsequence

    // Written bus numbers come back on the next read of the word, the latency timer on LATENCY_TIMER_O a cycle after the write
    upstream_write_a: assert property (
        bus_word_write_s ##1 bus_word_read_s |=> CFG_RSP_O.valid
            && CFG_RSP_O.rdata[7:0] == $past(CFG_REQ_I.wdata[7:0], 2))
        else $error("upstream bus number not kept");

    downstream_write_a: assert property (
        bus_word_write_s ##1 bus_word_read_s |=>
            CFG_RSP_O.rdata[15:8] == $past(CFG_REQ_I.wdata[15:8], 2))
        else $error("downstream bus number not kept");

    highest_write_a: assert property (
        bus_word_write_s ##1 bus_word_read_s |=>
            CFG_RSP_O.rdata[23:16] == $past(CFG_REQ_I.wdata[23:16], 2))
        else $error("highest bus number not kept");

    latency_write_a: assert property (
        bus_word_write_s |=> LATENCY_TIMER_O == $past(CFG_REQ_I.wdata[31:24]))
        else $error("latency timer not kept");

    io_capability_a: assert property (
        CFG_REQ_I.rd && io_word_hit |=> CFG_RSP_O.rdata[3:0] == 4'h1
            && CFG_RSP_O.rdata[11:8] == 4'h1 && CFG_RSP_O.rdata[31:16] == 16'h0000)
        else $error("capability nibble wrong");

    // Only the upper nibble of each window byte takes the written value
    io_bottom_write_a: assert property (
        io_word_write_s ##1 io_word_read_s |=>
            CFG_RSP_O.rdata[7:4] == $past(CFG_REQ_I.wdata[7:4], 2))
        else $error("bottom nibble not kept");

    io_top_write_a: assert property (
        io_word_write_s ##1 io_word_read_s |=>
            CFG_RSP_O.rdata[15:12] == $past(CFG_REQ_I.wdata[15:12], 2))
        else $error("top nibble not kept");

    io_bottom_edge_a: assert property (
        IO_VALID_I && IO_ADDR_I == {IO_BASE_UPPER_I, io_window_bottom_nibble_q, 12'h000}
            && io_window_top_nibble_q >= io_window_bottom_nibble_q
            && IO_LIMIT_UPPER_I == IO_BASE_UPPER_I |=> IO_RSP_O.forward)
        else $error("bottom edge not forwarded");

    io_top_edge_a: assert property (
        IO_VALID_I && IO_ADDR_I == {IO_LIMIT_UPPER_I, io_window_top_nibble_q, 12'hFFF}
            && IO_LIMIT_UPPER_I == IO_BASE_UPPER_I
            && io_window_top_nibble_q >= io_window_bottom_nibble_q |=> IO_RSP_O.forward)
        else $error("top edge not forwarded");

    io_outside_a: assert property (
        IO_VALID_I && (IO_ADDR_I < io_bottom_addr || IO_ADDR_I > io_top_addr)
            |=> IO_RSP_O.valid && !IO_RSP_O.forward)
        else $error("outside address forwarded");

    io_upper_a: assert property (
        IO_VALID_I && IO_ADDR_I[31:16] < IO_BASE_UPPER_I |=> !IO_RSP_O.forward)
        else $error("base extension ignored");

    io_limit_upper_a: assert property (
        IO_VALID_I && IO_ADDR_I[31:16] > IO_LIMIT_UPPER_I |=> !IO_RSP_O.forward)
        else $error("limit extension ignored");

    type0_match_a: assert property (
        CFG1_VALID_I && CFG1_BUS_I == downstream_bus_q
            |=> CFG1_RSP_O.to_type0 && !CFG1_RSP_O.pass_type1 && !CFG1_RSP_O.unclaimed)
        else $error("type-0 conversion missed");

    type1_pass_a: assert property (
        CFG1_VALID_I && CFG1_BUS_I > downstream_bus_q && CFG1_BUS_I <= highest_below_q
            |=> CFG1_RSP_O.pass_type1 && !CFG1_RSP_O.to_type0)
        else $error("type-1 pass missed");

    // A bus outside the downstream range is flagged and never forwarded
    type1_unclaimed_a: assert property (
        CFG1_VALID_I && CFG1_BUS_I != downstream_bus_q
            && (CFG1_BUS_I < downstream_bus_q || CFG1_BUS_I > highest_below_q)
            |=> CFG1_RSP_O.valid && CFG1_RSP_O.unclaimed
            && !CFG1_RSP_O.to_type0 && !CFG1_RSP_O.pass_type1)
        else $error("unclaimed type-1 not flagged");

endmodule

// File: sim/test_bridge_bus_number_io_window_regs.sv
// Self-checking bench for the bus number and I/O window register bank
`timescale 1ns/1ps
module test_bridge_bus_number_io_window_regs;
    // Decode case: request inputs beside the verdicts they should give
    typedef struct packed {
        logic [7:0] bus;
        logic [31:0] addr;
        logic [2:0] t1;
        logic fwd;
    } bbn_row_type;

    // ************************************************
    // Stimulus signals and counters
    // ************************************************
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    bbn_pkg::bbn_cfg_req_type req = '0;
    bbn_pkg::bbn_cfg_rsp_type rsp;
    logic [15:0] base_up = 16'h0001;
    logic [15:0] lim_up = 16'h0001;
    logic cfg1_valid = 1'b0;
    logic [7:0] cfg1_bus = 8'h00;
    bbn_pkg::bbn_cfg1_rsp_type t1_rsp;
    logic io_valid = 1'b0;
    logic [31:0] io_addr = 32'h0000_0000;
    bbn_pkg::bbn_io_rsp_type io_rsp;
    logic [7:0] up_bus;
    logic [7:0] lat;
    int miscompares = 0;
    int checks = 0;
    // Window 0001_3000..0001_5FFF, downstream 05h, highest below 08h
    bbn_row_type rows [6] = '{
        '{8'h05, 32'h0001_3000, 3'b100, 1'b1},
        '{8'h06, 32'h0001_2FFF, 3'b010, 1'b0},
        '{8'h08, 32'h0001_5FFF, 3'b010, 1'b1},
        '{8'h09, 32'h0001_6000, 3'b001, 1'b0},
        '{8'h04, 32'h0000_4000, 3'b001, 1'b0},
        '{8'h00, 32'h0002_4000, 3'b001, 1'b0}
    };

    // 200 MHz core clock
    always #2.5 core_clk = ~core_clk;

    bbn_regs DUT (
        .CORE_CLK_I(core_clk),
        .RST_N_I(rst_n),
        .CFG_REQ_I(req),
        .CFG_RSP_O(rsp),
        .IO_BASE_UPPER_I(base_up),
        .IO_LIMIT_UPPER_I(lim_up),
        .CFG1_VALID_I(cfg1_valid),
        .CFG1_BUS_I(cfg1_bus),
        .CFG1_RSP_O(t1_rsp),
        .IO_VALID_I(io_valid),
        .IO_ADDR_I(io_addr),
        .IO_RSP_O(io_rsp),
        .UPSTREAM_BUS_O(up_bus),
        .LATENCY_TIMER_O(lat)
    );

    // ************************************************
    // Compare, access and closing tasks
    // ************************************************
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_dec(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write is left on the bus so a following read can come back to back
    task automatic cfg_wr(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{1'b1, 1'b0, idx, be, d};
    endtask

    // Read answer stands for one cycle only, so it is sampled just after that edge
    task automatic cfg_rd(input logic [5:0] idx, input logic [31:0] exp);
        @(posedge core_clk);
        req <= '{1'b0, 1'b1, idx, 4'hF, 32'h0000_0000};
        @(posedge core_clk);
        req <= '0;
        #1;
        cmp_dec({3'b000, rsp.valid}, 4'h1);
        cmp_word(rsp.rdata, exp);
    endtask

    // Both decoders are strobed together and sampled in the answer cycle
    task automatic decode(input logic [7:0] bus, input logic [31:0] addr);
        @(posedge core_clk);
        cfg1_valid <= 1'b1;
        cfg1_bus <= bus;
        io_valid <= 1'b1;
        io_addr <= addr;
        @(posedge core_clk);
        cfg1_valid <= 1'b0;
        io_valid <= 1'b0;
        #1;
    endtask

    task automatic test_done;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Cuts a hang short
    initial
    begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        test_done;
    end

    // Reset values, programming, table of decode cases, then awkward cases
    initial
    begin
        @(posedge core_clk);
        #1;
        cmp_word({15'h0000, rsp.valid, up_bus, lat}, 32'h0000_0000);
        @(posedge core_clk);
        rst_n <= 1'b1;
        cfg_rd(6'h06, 32'h0000_0000);
        cfg_rd(6'h07, 32'h0000_0101);
        cfg_wr(6'h06, 4'hF, 32'h4008_0502);
        cfg_wr(6'h07, 4'hF, 32'hAAAA_5F3E);
        cfg_rd(6'h07, 32'h0000_5131);
        cfg_rd(6'h06, 32'h4008_0502);
        cmp_word({16'h0000, up_bus, lat}, 32'h0000_0240);
        foreach (rows[i])
        begin
            decode(rows[i].bus, rows[i].addr);
            cmp_dec({t1_rsp.valid, t1_rsp.to_type0, t1_rsp.pass_type1, t1_rsp.unclaimed},
                {1'b1, rows[i].t1});
            cmp_dec({2'b00, io_rsp.valid, io_rsp.forward},
                {3'b001, rows[i].fwd});
        end
        // Single lane write, unmapped word written and read
        cfg_wr(6'h06, 4'h8, 32'h7711_2233);
        cfg_wr(6'h05, 4'hF, 32'hFFFF_FFFF);
        cfg_rd(6'h05, 32'h0000_0000);
        cfg_rd(6'h06, 32'h7708_0502);
        @(posedge core_clk);
        #1;
        cmp_dec({3'b000, rsp.valid}, 4'h0);
        cmp_word({16'h0000, up_bus, lat}, 32'h0000_0277);
        // Top upper bits moved: window now spans into the next 64 KiB
        @(posedge core_clk);
        lim_up <= 16'h0002;
        decode(8'h05, 32'h0002_0000);
        cmp_dec({2'b00, io_rsp.valid, io_rsp.forward}, 4'h3);
        decode(8'h05, 32'h0002_6000);
        cmp_dec({2'b00, io_rsp.valid, io_rsp.forward}, 4'h2);
        // Second reset in mid-run must restore every reset value
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        #1;
        cmp_word({16'h0000, up_bus, lat}, 32'h0000_0000);
        @(posedge core_clk);
        rst_n <= 1'b1;
        cfg_rd(6'h06, 32'h0000_0000);
        cfg_rd(6'h07, 32'h0000_0101);
        test_done;
    end
endmodule
